// ==== src/zcv_top.v ====
// Zero-crossing volume update control for eight analog channels.
// Assumes serial port pins and zero-cross comparators are asynchronous.
//
// Notes on behaviour
// [R1] 473 quarter-dB codes, -96 to +22 dB
// [R2] Apply volume immediately or at zero crossing
// [R3] Eight time-outs, 5 to 50 ms, force apply
// [R4] Second command: apply earlier or drop it
// [R5] Serial or two-wire port, own and group address
// [R6] Host holds mute active at least 2 ms
// [R7] Mute polarity set by configuration bit
// [R8] Host waits 100 ns after reset release
// [R9] Each channel drives its tap switches
// [R10] Restart time-out on new pending, clear on apply
`include "zcv_map.vh"
module zcv_top #(
  parameter MS_CYCLES = `ZCV_CYC_PER_MS
) (
  // Clock, reset, enable
  input wire CLK,
  input wire RST_N,
  input wire CE,
  // Control port pins
  input wire I2C_SEL,
  input wire SERIAL_PORT_CLOCK,
  input wire SERIAL_PORT_DATA_IN,
  input wire SERIAL_PORT_CS_N,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire [6:0] DEV_ADDR,
  input wire [6:0] GROUP_ADDR,
  // Analog side
  input wire [`ZCV_CH_N-1:0] ZERO_CROSS,
  input wire MUTE_IN,
  output reg MUTE_ACTIVE,
  output reg [`ZCV_CH_N*`ZCV_VOL_W-1:0] TAP_SEL,
  output reg [`ZCV_CH_N-1:0] CH_PENDING,
  output reg [`ZCV_CFG_W-1:0] CFG_OUT
);

  localparam ST_IDLE = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_SKIP = 4'h8;

  // ===================================================================
  // Input synchronisation
  wire [`ZCV_CH_N+3:0] sync_q;
  zcv_sync #(.W(`ZCV_CH_N + 4)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .d({ZERO_CROSS, MUTE_IN, SERIAL_PORT_CLOCK, ~SERIAL_PORT_DATA_IN,
        ~SERIAL_PORT_CS_N}),
    .q(sync_q)
  );
  wire [`ZCV_CH_N-1:0] zc_s = sync_q[`ZCV_CH_N+3:4];
  wire mute_s = sync_q[3];
  wire sclk_s = sync_q[2];
  // Data and select enter inverted, so the reset value reads as idle
  // and no false start or end of frame follows reset
  wire sdat_s = ~sync_q[1];
  wire scs_n_s = ~sync_q[0];

  reg sclk_d_ff, sdat_d_ff, scs_n_d_ff;
  reg [`ZCV_CH_N-1:0] zc_d_ff;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_d_ff <= 1'b0;
      sdat_d_ff <= 1'b1;
      scs_n_d_ff <= 1'b1;
      zc_d_ff <= {`ZCV_CH_N{1'b0}};
    end else if (CE) begin
      sclk_d_ff <= sclk_s;
      sdat_d_ff <= sdat_s;
      scs_n_d_ff <= scs_n_s;
      zc_d_ff <= zc_s;
    end
  end

  // ===================================================================
  // Frame framing: chip select for SPI, start and stop for I2C
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire i2c_hi = I2C_SEL & sclk_s & sclk_d_ff;
  wire frm_begin = I2C_SEL ? (i2c_hi & sdat_d_ff & ~sdat_s)
                           : (scs_n_d_ff & ~scs_n_s);
  wire frm_end = I2C_SEL ? (i2c_hi & ~sdat_d_ff & sdat_s)
                         : (~scs_n_d_ff & scs_n_s);

  reg [3:0] state_ff;
  reg [3:0] bit_ff;
  reg [7:0] sh_ff;
  reg [1:0] byte_ff;
  reg [7:0] tgt_ff;
  reg [7:0] hi_ff;
  reg ack_pend_ff;
  reg wr_ff;
  reg [7:0] wr_lo_ff;

  wire byte_done = sclk_rise & (bit_ff == `ZCV_BIT_LAST);
  wire [7:0] rx_byte = {sh_ff[6:0], sdat_s};
  wire addr_hit = ~rx_byte[0] &
                  ((rx_byte[7:1] == DEV_ADDR) | (rx_byte[7:1] == GROUP_ADDR));

  // Shared receiver: writes only, so read requests are left unanswered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      byte_ff <= 2'h0;
      tgt_ff <= 8'h00;
      hi_ff <= 8'h00;
      ack_pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      wr_lo_ff <= 8'h00;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
    end else if (CE) begin
      wr_ff <= 1'b0;
      if (frm_end) begin
        state_ff <= ST_IDLE;
        SDA_OE <= 1'b0;
        ack_pend_ff <= 1'b0;
      end else if (frm_begin) begin
        state_ff <= ST_ADDR;
        bit_ff <= 4'h0;
        byte_ff <= 2'h0;
        ack_pend_ff <= 1'b0;
      end else begin
        if (sclk_fall) begin
          SDA_OE <= I2C_SEL & ack_pend_ff & (bit_ff == `ZCV_BIT_ACK);
          if (bit_ff == `ZCV_BIT_ACK)
            ack_pend_ff <= 1'b0;
        end
        if (sclk_rise && state_ff != ST_IDLE) begin
          if (bit_ff == `ZCV_BIT_ACK) begin
            bit_ff <= 4'h0;
          end else if (byte_done) begin
            bit_ff <= I2C_SEL ? `ZCV_BIT_ACK : 4'h0;
          end else begin
            bit_ff <= bit_ff + 4'h1;
          end
          if (bit_ff != `ZCV_BIT_ACK)
            sh_ff <= rx_byte;
        end
        if (byte_done) begin
          case (state_ff)
            ST_ADDR: begin
              state_ff <= addr_hit ? ST_DATA : ST_SKIP; // [R5]
              ack_pend_ff <= addr_hit;
            end
            ST_DATA: begin
              ack_pend_ff <= 1'b1;
              if (byte_ff == 2'h0)
                tgt_ff <= rx_byte;
              if (byte_ff == 2'h1)
                hi_ff <= rx_byte;
              if (byte_ff == `ZCV_BYTE_LAST) begin
                wr_ff <= 1'b1;
                wr_lo_ff <= rx_byte;
                byte_ff <= 2'h0;
              end else begin
                byte_ff <= byte_ff + 2'h1;
              end
            end
            ST_SKIP: begin
              state_ff <= ST_SKIP;
            end
            default: begin
              state_ff <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ===================================================================
  // Command decode
  wire [`ZCV_VOL_W:0] raw_code = {1'b0, hi_ff[0], wr_lo_ff};
  // Codes past +22 dB are clamped rather than wrapped
  wire [`ZCV_VOL_W-1:0] wr_code = (raw_code > {1'b0, `ZCV_VOL_MAX}) ?
    `ZCV_VOL_MAX : raw_code[`ZCV_VOL_W-1:0]; // [R1]
  wire wr_cfg = wr_ff & (tgt_ff == `ZCV_TGT_CFG);
  wire wr_all = wr_ff & (tgt_ff == `ZCV_TGT_ALL);
  wire wr_one = wr_ff & (tgt_ff[7:3] == 5'h00);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      CFG_OUT <= `ZCV_CFG_RST;
    else if (CE && wr_cfg)
      CFG_OUT <= wr_lo_ff[`ZCV_CFG_W-1:0];
  end

  wire zc_en = CFG_OUT[`ZCV_CFG_ZC_EN];
  wire keep_prev = CFG_OUT[`ZCV_CFG_KEEP_PREV];

  // ===================================================================
  // Mute input: the host keeps it 2 ms, far above sync latency
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      MUTE_ACTIVE <= 1'b0;
    else if (CE)
      MUTE_ACTIVE <= (mute_s == CFG_OUT[`ZCV_CFG_MUTE_LVL]); // [R7] [R6]
  end

  // ===================================================================
  // Time-out selection
  function [`ZCV_CNT_W-1:0] to_cycles;
    input [2:0] sel;
    reg [31:0] ms;
    reg [31:0] cyc;
    begin
      case (sel)
        3'h0: ms = `ZCV_TO0_MS;
        3'h1: ms = `ZCV_TO1_MS;
        3'h2: ms = `ZCV_TO2_MS;
        3'h3: ms = `ZCV_TO3_MS;
        3'h4: ms = `ZCV_TO4_MS;
        3'h5: ms = `ZCV_TO5_MS;
        3'h6: ms = `ZCV_TO6_MS;
        default: ms = `ZCV_TO7_MS;
      endcase
      cyc = ms * MS_CYCLES;
      to_cycles = cyc[`ZCV_CNT_W-1:0];
    end
  endfunction

  wire [`ZCV_CNT_W-1:0] to_load =
    to_cycles(CFG_OUT[`ZCV_CFG_TO_HI:`ZCV_CFG_TO_LO]); // [R3]

  // ===================================================================
  // Per-channel pending volume and tap drive
  genvar gi;
  generate
    for (gi = 0; gi < `ZCV_CH_N; gi = gi + 1) begin : g_ch
      reg [`ZCV_VOL_W-1:0] pend_ff;
      reg [`ZCV_CNT_W-1:0] cnt_ff;
      wire hit = wr_all | (wr_one & (tgt_ff[2:0] == gi));
      wire zc_ev = zc_s[gi] ^ zc_d_ff[gi];
      wire expire = (cnt_ff == {{(`ZCV_CNT_W-1){1'b0}}, 1'b1});
      always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          pend_ff <= {`ZCV_VOL_W{1'b0}};
          cnt_ff <= {`ZCV_CNT_W{1'b0}};
          CH_PENDING[gi] <= 1'b0;
          TAP_SEL[gi*`ZCV_VOL_W +: `ZCV_VOL_W] <= {`ZCV_VOL_W{1'b0}};
        end else if (CE) begin
          if (hit && !zc_en) begin
            TAP_SEL[gi*`ZCV_VOL_W +: `ZCV_VOL_W] <= wr_code; // [R2] [R9]
            CH_PENDING[gi] <= 1'b0;
            cnt_ff <= {`ZCV_CNT_W{1'b0}};
          end else if (hit) begin
            // A new command replaces what was pending, applying it first when keep_prev is set
            if (CH_PENDING[gi] && keep_prev)
              TAP_SEL[gi*`ZCV_VOL_W +: `ZCV_VOL_W] <= pend_ff; // [R4]
            pend_ff <= wr_code; // [R4]
            CH_PENDING[gi] <= 1'b1; // [R2]
            cnt_ff <= to_load; // [R10]
          end else if (CH_PENDING[gi] && (zc_ev || expire)) begin
            TAP_SEL[gi*`ZCV_VOL_W +: `ZCV_VOL_W] <= pend_ff; // [R3] [R9]
            CH_PENDING[gi] <= 1'b0;
            cnt_ff <= {`ZCV_CNT_W{1'b0}}; // [R10]
          end else if (CH_PENDING[gi]) begin
            cnt_ff <= cnt_ff - {{(`ZCV_CNT_W-1){1'b0}}, 1'b1}; // [R3]
          end
        end
      end
    end
  endgenerate
endmodule // zcv_top

// ==== src/zcv_map.vh ====
// Constants of the zero-crossing volume update control block.
// Assumes a 100 MHz CLK; included by bare name from the design files.
`ifndef ZCV_MAP_VH
`define ZCV_MAP_VH
// =====================================================================
// Channels and volume code
`define ZCV_CH_N 8
`define ZCV_VOL_W 9
`define ZCV_VOL_MAX 9'h1d8
// =====================================================================
// Serial frame targets
`define ZCV_TGT_CFG 8'h08
`define ZCV_TGT_ALL 8'h0f
`define ZCV_BYTE_LAST 2'h2
`define ZCV_BIT_LAST 4'h7
`define ZCV_BIT_ACK 4'h8
// =====================================================================
// Configuration byte fields
`define ZCV_CFG_W 6
`define ZCV_CFG_RST 6'h00
`define ZCV_CFG_MUTE_LVL 0
`define ZCV_CFG_ZC_EN 1
`define ZCV_CFG_TO_LO 2
`define ZCV_CFG_TO_HI 4
`define ZCV_CFG_KEEP_PREV 5
// =====================================================================
// Time-out periods in ms and clock cycles per ms at 100 MHz
`define ZCV_CYC_PER_MS 100000
`define ZCV_TO0_MS 5
`define ZCV_TO1_MS 10
`define ZCV_TO2_MS 15
`define ZCV_TO3_MS 20
`define ZCV_TO4_MS 25
`define ZCV_TO5_MS 30
`define ZCV_TO6_MS 40
`define ZCV_TO7_MS 50
`define ZCV_CNT_W 23
`endif

// ==== src/zcv_sync.v ====
// Two-flop synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; no word coherency is given.
module zcv_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // zcv_sync

// ==== bench/zcv_properties.sv ====
// Port assertions of the volume update control.
// Assumes CE high and a small MS_CYCLES in simulation.
`include "zcv_map.vh"
module zcv_props #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Pins watched
  input wire I2C_SEL,
  input wire SDA_OE,
  input wire MUTE_IN,
  input wire MUTE_ACTIVE,
  input wire [`ZCV_CH_N*`ZCV_VOL_W-1:0] TAP_SEL,
  input wire [`ZCV_CH_N-1:0] CH_PENDING,
  input wire [`ZCV_CFG_W-1:0] CFG_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==================================================================
  // Properties
  localparam int TO_LO = 5 * MS_CYCLES - 3;
  localparam int TO_HI = 5 * MS_CYCLES + 3;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_code_range: assert property (
    TAP_SEL[71:63] <= `ZCV_VOL_MAX) else $error("Code above top");
  a_pend_zc_only: assert property (
    $rose(CH_PENDING[0]) |-> CFG_OUT[1]) else $error("Pend with zc off");
  // Only the shortest period is bounded here; longer ones in the bench
  a_timeout_apply: assert property (
    $rose(CH_PENDING[0]) && CFG_OUT[4:2] == 3'h0 |->
    ##[TO_LO:TO_HI] !CH_PENDING[0]) else $error("Time-out missed");
  a_drop_mode: assert property (
    $changed(TAP_SEL[8:0]) && CFG_OUT[1] && !CFG_OUT[5] |->
    !CH_PENDING[0]) else $error("Earlier code applied");
  a_sda_quiet: assert property (
    !I2C_SEL |-> !SDA_OE) else $error("Ack in SPI mode");
  a_mute_on: assert property (
    (MUTE_IN == CFG_OUT[0]) [*4] |-> MUTE_ACTIVE) else $error("Mute lost");
  a_mute_off: assert property (
    (MUTE_IN != CFG_OUT[0]) [*4] |-> !MUTE_ACTIVE) else $error("False mute");
  a_apply_taps: assert property (
    $fell(CH_PENDING[0]) |-> $changed(TAP_SEL[8:0])) else $error("No apply");
endmodule // zcv_props

bind zcv_top zcv_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .CLK(CLK), .RST_N(RST_N), .I2C_SEL(I2C_SEL), .SDA_OE(SDA_OE),
  .MUTE_IN(MUTE_IN), .MUTE_ACTIVE(MUTE_ACTIVE), .TAP_SEL(TAP_SEL),
  .CH_PENDING(CH_PENDING), .CFG_OUT(CFG_OUT));

// ==== bench/zcv_host.sv ====
// Serial host model: SPI and two-wire write frames, MSB first, 80 ns.
// Assumes the block samples data on the rising serial clock.
module zcv_host (
  // Timing reference
  input wire clk,
  // Serial pins
  output logic sclk,
  output logic sdi,
  output logic cs_n,
  // Resolved data line, for the ack slots
  input wire sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Clock stands low between frames; data shows its inverse when released
  task automatic wr(input logic [31:0] f);
    half();
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      half();
      sclk = 1'b0;
      sdi = f[i];
      half();
      sclk = 1'b1;
    end
    half();
    sclk = 1'b0;
    sdi = ~sdi;
    half();
    cs_n = 1'b1;
  endtask
  // Two-wire write: start, four bytes each with an ack slot, stop
  task automatic i2c_wr(input logic [31:0] f, output logic [3:0] ack);
    half();
    sclk = 1'b1;
    sdi = 1'b1;
    half();
    sdi = 1'b0;
    for (int b = 3; b >= 0; b--) begin
      for (int i = 8; i >= 0; i--) begin
        half();
        sclk = 1'b0;
        sdi = (i == 0) ? 1'b1 : f[b * 8 + i - 1];
        half();
        sclk = 1'b1;
      end
      ack[b] = ~sda;
    end
    half();
    sclk = 1'b0;
    sdi = 1'b0;
    half();
    sclk = 1'b1;
    half();
    sdi = 1'b1;
  endtask
endmodule // zcv_host

// ==== bench/tb.sv ====
// Self-checking bench of the volume update control, SPI and two-wire.
// Assumes zcv_host on the serial pins and 10 cycles per ms.
`include "zcv_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==================================================================
  // Signals
  localparam int MS = 10;
  localparam logic [6:0] DEV = 7'h15;
  localparam logic [6:0] GRP = 7'h6a;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic MUTE_IN = 1'b0;
  logic [7:0] ZERO_CROSS = 8'h00;
  logic I2C_SEL = 1'b0;
  logic [3:0] k;
  wire sclk, sdi, cs_n, MUTE_ACTIVE, SDA_OUT, SDA_OE;
  // Pulled-up data line: the host releases it high, the block pulls low
  wire sda = sdi & (~SDA_OE | SDA_OUT);
  wire [`ZCV_CH_N*`ZCV_VOL_W-1:0] TAP_SEL;
  wire [`ZCV_CH_N-1:0] CH_PENDING;
  wire [`ZCV_CFG_W-1:0] CFG_OUT;
  int err_count = 0;
  int n_tests = 0;
  int n;
  int to_ms [8] = '{5, 10, 15, 20, 25, 30, 40, 50};
  logic [7:0] t;
  logic [8:0] c, e;
  logic [2:0] ch;
  // Rows: target, code, channel looked at, its expected code
  logic [28:0] rows [5] = '{{8'h00, 9'h000, 3'h0, 9'h000},
    {8'h07, 9'h1d8, 3'h7, 9'h1d8}, {8'h03, 9'h1ff, 3'h3, 9'h1d8},
    {8'h0f, 9'h180, 3'h5, 9'h180}, {8'h09, 9'h011, 3'h5, 9'h180}};
  zcv_top #(.MS_CYCLES(MS)) dut (
    .CLK(CLK), .RST_N(RST_N), .CE(1'b1), .I2C_SEL(I2C_SEL),
    .SERIAL_PORT_CLOCK(sclk), .SERIAL_PORT_DATA_IN(sda),
    .SERIAL_PORT_CS_N(cs_n), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .DEV_ADDR(DEV), .GROUP_ADDR(GRP), .ZERO_CROSS(ZERO_CROSS),
    .MUTE_IN(MUTE_IN), .MUTE_ACTIVE(MUTE_ACTIVE), .TAP_SEL(TAP_SEL),
    .CH_PENDING(CH_PENDING), .CFG_OUT(CFG_OUT));
  zcv_host host (.clk(CLK), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .sda(sda));
  always #5 CLK = ~CLK;
  // ==================================================================
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task automatic put(input logic [6:0] a, input logic [7:0] g,
                     input logic [8:0] v);
    host.wr({a, 1'b0, g, 7'h00, v});
  endtask
  task automatic chk(input string s, input logic [8:0] x,
                     input logic [8:0] g);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==================================================================
  // Sequence
  initial begin
    #300000;
    err_count++;
    end_of_test();
  end
  initial begin
    tick(2);
    RST_N = 1'b1;
    tick(10);
    chk("taps", 9'h000, TAP_SEL[8:0]);
    chk("cfg", 9'h000, CFG_OUT);
    foreach (rows[i]) begin
      {t, c, ch, e} = rows[i];
      put(DEV, t, c);
      chk("tap", e, TAP_SEL[ch*9 +: 9]);
    end
    put(7'h16, 8'h01, 9'h055);
    chk("other addr", 9'h180, TAP_SEL[17:9]);
    put(GRP, 8'h01, 9'h0aa);
    chk("group addr", 9'h0aa, TAP_SEL[17:9]);
    host.wr({DEV, 1'b1, 8'h01, 7'h00, 9'h033});
    chk("read bit", 9'h0aa, TAP_SEL[17:9]);
    tick(40);
    chk("mute low", 9'h001, MUTE_ACTIVE);
    put(DEV, `ZCV_TGT_CFG, 9'h001);
    tick(4);
    chk("mute pol", 9'h000, MUTE_ACTIVE);
    MUTE_IN = 1'b1;
    tick(40);
    chk("mute high", 9'h001, MUTE_ACTIVE);
    for (int s = 0; s < 8; s++) begin
      put(DEV, `ZCV_TGT_CFG, {4'h0, s[2:0], 2'b10});
      put(DEV, 8'h00, {5'h00, s[2:0], 1'b1});
      for (n = 0; CH_PENDING[0] === 1'b1 && n < 600; n++) tick(1);
      e = (n inside {[to_ms[s] * MS - 9:to_ms[s] * MS - 1]});
      chk("time-out", 9'h001, e);
    end
    // Drop mode: second code replaces the first and restarts the wait
    put(DEV, 8'h00, 9'h100);
    chk("pending", 9'h001, CH_PENDING[0]);
    chk("held", 9'h00f, TAP_SEL[8:0]);
    put(DEV, 8'h00, 9'h101);
    tick(300);
    chk("restart", 9'h001, CH_PENDING[0]);
    chk("drop", 9'h00f, TAP_SEL[8:0]);
    ZERO_CROSS = 8'h01;
    tick(5);
    chk("zc apply", 9'h101, TAP_SEL[8:0]);
    chk("zc clear", 9'h000, CH_PENDING[0]);
    put(DEV, `ZCV_TGT_CFG, 9'h03e);
    put(DEV, 8'h00, 9'h120);
    put(DEV, 8'h00, 9'h121);
    chk("keep", 9'h120, TAP_SEL[8:0]);
    for (n = 0; CH_PENDING[0] === 1'b1 && n < 520; n++) tick(1);
    chk("keep last", 9'h121, TAP_SEL[8:0]);
    // Two-wire framing: acks for own and group address, none otherwise
    I2C_SEL = 1'b1;
    host.i2c_wr({DEV, 1'b0, `ZCV_TGT_CFG, 16'h0000}, k);
    chk("i2c cfg", 9'h000, CFG_OUT);
    chk("acks own", 9'h00f, k);
    host.i2c_wr({GRP, 1'b0, 8'h02, 16'h01c4}, k);
    chk("i2c tap", 9'h1c4, TAP_SEL[26:18]);
    chk("acks group", 9'h00f, k);
    host.i2c_wr({7'h16, 1'b0, 8'h02, 16'h0005}, k);
    chk("i2c other", 9'h1c4, TAP_SEL[26:18]);
    chk("acks none", 9'h000, k);
    chk("sda free", 9'h000, SDA_OE);
    end_of_test();
  end
endmodule // tb
